/* verilog/lac_pkg.sv */
// Purpose: Shared constants and types for the LED actuation control block
// Assumes: Wishbone classic slave, byte-wide registers in the low data bits
// Notes:   Offsets are byte indices; byte address is four times the index
package lac_pkg;
  localparam int          LAC_CHANNELS     = 8;
  localparam int          LAC_ADR_W        = 10;
  localparam logic [7:0]  LAC_IDX_LINK     = 8'h72;
  localparam logic [7:0]  LAC_IDX_POL      = 8'h73;
  localparam logic [7:0]  LAC_IDX_DRIVE    = 8'h74;
  localparam logic [7:0]  LAC_IDX_MODE_LO  = 8'h81;
  localparam logic [7:0]  LAC_IDX_MODE_HI  = 8'h82;
  localparam logic [7:0]  LAC_IDX_STATUS   = 8'h90;
  localparam logic [7:0]  LAC_RST_BYTE     = 8'h00;
  localparam int          LAC_MODE_LSB_STEP = 2;
  localparam logic [31:0] LAC_RD_UNMAPPED  = 32'h0000_0000;

  typedef enum logic [1:0] {
    LAC_MODE_DIRECT  = 2'b00,
    LAC_MODE_PULSE1  = 2'b01,
    LAC_MODE_PULSE2  = 2'b10,
    LAC_MODE_BREATHE = 2'b11
  } lac_mode_t;

  typedef enum logic [3:0] {
    LAC_ST_IDLE  = 4'b0001,
    LAC_ST_RUN   = 4'b0010,
    LAC_ST_PULSE = 4'b0100,
    LAC_ST_FINISH = 4'b1000
  } lac_state_t;

  // Per-channel command to the waveform generator
  typedef struct packed {
    logic      actuate;
    logic      pulsing;
    logic      restart;
    logic      non_inv;
    lac_mode_t mode;
  } lac_chan_cmd_t;
endpackage

/* verilog/lac_top.sv */
// Purpose: Eight-channel LED actuation control with Wishbone registers
// Assumes: Waveform generators outside report breath and pulse ends
// Notes:   Sensor and generator inputs are synchronised by two flops
// How it works
// - Eight-bit drive request register, reset zero
// - Linked LED actuated by sensor touch
// - Unlinked LED follows its request bit
// - Request 0 minimum duty, 1 actuated
// - Inverted idle: low for minimum duty
// - Non-inverted idle: high for minimum duty
// - Non-inverted active ramps max to min
// - Two mode registers, four LEDs each
// - Highest LED in bits 7:6
// - Linked behavior starts and stops on triggers
// - Unlinked bit 1 touch, 0 release
// - Idle pin level set by polarity
// - Unlinked breath finishes before mode change
// - Pulse1 unlinked ignores bit until done
// - Link change follows new source at once
// - Period change restarts breath, keeps counts
// - Mode decode direct, pulse1, pulse2, breathe
// - Sensor link register, reset zero
// - Polarity register, 0 inverted, reset zero
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module lac_top
  import lac_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic [LAC_ADR_W-1:0]    wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [7:0]              sensor_touch,
  input  wire logic [7:0]              breath_done,
  input  wire logic [7:0]              pulses_done,
  input  wire logic                    period_changed,
  output lac_chan_cmd_t [7:0]          chan_cmd
);

  // Register state
  logic [7:0]        drive_q, drive_d;
  logic [7:0]        link_q, link_d;
  logic [7:0]        pol_q, pol_d;
  logic [7:0]        mode_lo_q, mode_lo_d;
  logic [7:0]        mode_hi_q, mode_hi_d;
  logic [31:0]       rdat_q, rdat_d;
  logic              ack_q, ack_d;
  logic [7:0]        touch_s1_q, touch_s2_q;
  logic [7:0]        bdone_s1_q, bdone_s2_q;
  logic [7:0]        pdone_s1_q, pdone_s2_q;
  logic [1:0]        per_s_q;
  logic [7:0]        act_seen;
  logic [15:0]       mode_all;
  logic [7:0]        wb_idx;
  logic              wr_en;

  assign wb_idx   = wb_adr_i[9:2];
  assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
  assign mode_all = {mode_hi_q, mode_lo_q};

  // Register writes and read data
  always_comb begin
    drive_d   = drive_q;
    link_d    = link_q;
    pol_d     = pol_q;
    mode_lo_d = mode_lo_q;
    mode_hi_d = mode_hi_q;
    ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d    = LAC_RD_UNMAPPED;
    if (wr_en) begin
      case (wb_idx)
        LAC_IDX_DRIVE:   drive_d   = wb_dat_i[7:0];
        LAC_IDX_LINK:    link_d    = wb_dat_i[7:0];
        LAC_IDX_POL:     pol_d     = wb_dat_i[7:0];
        LAC_IDX_MODE_LO: mode_lo_d = wb_dat_i[7:0];
        LAC_IDX_MODE_HI: mode_hi_d = wb_dat_i[7:0];
        default: ;
      endcase
    end
    case (wb_idx)
      LAC_IDX_DRIVE:   rdat_d = {24'h000000, drive_q};
      LAC_IDX_LINK:    rdat_d = {24'h000000, link_q};
      LAC_IDX_POL:     rdat_d = {24'h000000, pol_q};
      LAC_IDX_MODE_LO: rdat_d = {24'h000000, mode_lo_q};
      LAC_IDX_MODE_HI: rdat_d = {24'h000000, mode_hi_q};
      LAC_IDX_STATUS:  rdat_d = {24'h000000, act_seen};
      default:         rdat_d = LAC_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      drive_q    <= LAC_RST_BYTE;
      link_q     <= LAC_RST_BYTE;
      pol_q      <= LAC_RST_BYTE;
      mode_lo_q  <= LAC_RST_BYTE;
      mode_hi_q  <= LAC_RST_BYTE;
      rdat_q     <= LAC_RD_UNMAPPED;
      ack_q      <= 1'b0;
      touch_s1_q <= 8'h00;
      touch_s2_q <= 8'h00;
      bdone_s1_q <= 8'h00;
      bdone_s2_q <= 8'h00;
      pdone_s1_q <= 8'h00;
      pdone_s2_q <= 8'h00;
      per_s_q    <= 2'h0;
    end else begin
      drive_q    <= drive_d;
      link_q     <= link_d;
      pol_q      <= pol_d;
      mode_lo_q  <= mode_lo_d;
      mode_hi_q  <= mode_hi_d;
      rdat_q     <= rdat_d;
      ack_q      <= ack_d;
      touch_s1_q <= sensor_touch;
      touch_s2_q <= touch_s1_q;
      bdone_s1_q <= breath_done;
      bdone_s2_q <= bdone_s1_q;
      pdone_s1_q <= pulses_done;
      pdone_s2_q <= pdone_s1_q;
      per_s_q    <= {per_s_q[0], period_changed};
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  generate
    for (genvar g = 0; g < LAC_CHANNELS; g++) begin : g_chan
      lac_state_t    st_q, st_d;
      lac_mode_t     mode_q, mode_d;
      lac_mode_t     mode_req;
      lac_chan_cmd_t cmd_q, cmd_d;
      logic          src, src_prev_q, src_prev_d;
      logic          link_prev_q, link_prev_d;
      logic          touch_ev, release_ev;
      logic          link_chg;

      assign mode_req = lac_mode_t'(mode_all[g*LAC_MODE_LSB_STEP +: 2]);
      assign src        = link_q[g] ? touch_s2_q[g] : drive_q[g];
      assign link_chg   = link_q[g] != link_prev_q;
      assign touch_ev   = src && !src_prev_q;
      assign release_ev = !src && src_prev_q;

      always_comb begin
        st_d       = st_q;
        mode_d     = mode_q;
        src_prev_d = src;
        link_prev_d = link_q[g];
        cmd_d      = cmd_q;
        cmd_d.restart = 1'b0;
        case (st_q)
          LAC_ST_IDLE: begin
            mode_d = mode_req;
            if (src && (touch_ev || link_chg || mode_req != mode_q)) begin
              st_d = (mode_req == LAC_MODE_PULSE1) ? LAC_ST_PULSE : LAC_ST_RUN;
            end
          end
          LAC_ST_RUN: begin
            if (!src || release_ev) begin
              if (mode_q == LAC_MODE_PULSE2) begin
                st_d = LAC_ST_PULSE;
              end else if (mode_q == LAC_MODE_BREATHE && !link_q[g] && !link_chg) begin
                st_d = LAC_ST_FINISH;
              end else begin
                st_d = LAC_ST_IDLE;
              end
            end else if (mode_req != mode_q) begin
              if (mode_q == LAC_MODE_DIRECT || link_q[g]) begin
                st_d = LAC_ST_IDLE;
              end else begin
                st_d = LAC_ST_FINISH;
              end
            end
          end
          LAC_ST_PULSE: begin
            if (pdone_s2_q[g]) begin
              st_d = LAC_ST_IDLE;
            end
          end
          LAC_ST_FINISH: begin
            if (bdone_s2_q[g]) begin
              st_d = LAC_ST_IDLE;
            end
          end
          default: st_d = LAC_ST_IDLE;
        endcase
        cmd_d.actuate = st_d != LAC_ST_IDLE;
        cmd_d.pulsing = st_d == LAC_ST_PULSE;
        cmd_d.mode    = mode_d;
        cmd_d.non_inv = pol_q[g];
        if (per_s_q[1] && st_q != LAC_ST_IDLE) begin
          cmd_d.restart = 1'b1;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          st_q        <= LAC_ST_IDLE;
          mode_q      <= LAC_MODE_DIRECT;
          src_prev_q  <= 1'b0;
          link_prev_q <= 1'b0;
          cmd_q       <= '0;
        end else begin
          st_q        <= st_d;
          mode_q      <= mode_d;
          src_prev_q  <= src_prev_d;
          link_prev_q <= link_prev_d;
          cmd_q       <= cmd_d;
        end
      end

      assign chan_cmd[g] = cmd_q;
      assign act_seen[g] = cmd_q.actuate;
    end
  endgenerate

endmodule // lac_top

/* verification/lac_chk.sv */
// Purpose: Port checks for lac_top
// Assumes: Classic Wishbone master
// Notes:   Bound from tb
`timescale 1ns/1ps
module lac_chk
  import lac_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic [LAC_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic                wb_we_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                period_changed,
  input wire lac_chan_cmd_t [7:0] chan_cmd
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic       rq = wb_cyc_i & wb_stb_i;
  wire logic [7:0] ix = wb_adr_i[9:2];
  logic      [3:0] pc_q;
  // Cycles since period change
  always_ff @(posedge ref_clk)
    pc_q <= (sys_rst | period_changed) ? 4'h0 : pc_q + {3'h0, pc_q != 4'hf};
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_req_a: assert property (rq && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  ack_idle_a: assert property (!rq |=> !wb_ack_o) else $error("ack unasked");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
  unmap_rd_a: assert property (wb_ack_o && !wb_we_i && ix == 8'h00 |-> wb_dat_o == 32'h0)
    else $error("unmapped read");
  pol_map_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && ix == LAC_IDX_POL
    |=> chan_cmd[0].non_inv == $past(wb_dat_i[0]) && chan_cmd[7].non_inv == $past(wb_dat_i[7]))
    else $error("polarity map");
  sel_skip_a: assert property (wb_ack_o && wb_we_i && !wb_sel_i[0] && ix == LAC_IDX_POL
    |=> $stable(chan_cmd[0].non_inv)) else $error("write without sel");
  restart_src_a: assert property (chan_cmd[0].restart |-> pc_q < 4'h6)
    else $error("stray restart");
  rst_clear_a: assert property ($fell(sys_rst) |-> chan_cmd == '0 && !wb_ack_o)
    else $error("reset state");
  cover property (rq && wb_we_i && wb_ack_o);
  cover property (chan_cmd[0].restart);
  cover property ($fell(chan_cmd[0].actuate));
  cover property ($rose(chan_cmd[3].pulsing));
endmodule // lac_chk

/* verification/lac_led_gen.sv */
// Purpose: Waveform generator stand-in for eight channels
// Assumes: Breath lasts DLY cycles, done held 4 cycles
// Notes:   Done cleared one cycle after actuation ends
`timescale 1ns/1ps
module lac_led_gen
  import lac_pkg::*;
#(parameter int DLY = 20)
(
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire lac_chan_cmd_t [7:0] chan_cmd,
  output logic [7:0]              breath_done,
  output logic [7:0]              pulses_done
);
  logic [5:0] cnt_q [8];
  always_ff @(posedge ref_clk)
    for (int g = 0; g < 8; g++)
      cnt_q[g] <= (sys_rst || !chan_cmd[g].actuate || chan_cmd[g].restart
        || cnt_q[g] == 6'(DLY + 3)) ? 6'h0 : cnt_q[g] + 6'h1;
  always_comb
    for (int g = 0; g < 8; g++) begin
      breath_done[g] = cnt_q[g] >= 6'(DLY);
      pulses_done[g] = breath_done[g] & chan_cmd[g].pulsing;
    end
endmodule // lac_led_gen

/* verification/tb.sv */
// Purpose: Self-checking bench for lac_top
// Assumes: Status index reports actuation
// Notes:   Read results checked from a queue
`timescale 1ns/1ps
module tb
  import lac_pkg::*;
();
  logic ref_clk = 0, sys_rst = 1, we = 0, cyc = 0, stb = 0, pch = 0, rs_seen = 0, ack;
  logic [9:0] adr = '0;
  logic [31:0] dat = '0, r, rdat;
  logic [3:0] sel = '0;
  logic [7:0] touch = '0, bd, pd;
  lac_chan_cmd_t [7:0] cmd;
  logic [31:0] exp_q[$];
  int miscompares = 0, checks_done = 0;
  lac_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sensor_touch(touch), .breath_done(bd), .pulses_done(pd),
    .period_changed(pch), .chan_cmd(cmd));
  lac_led_gen u_gen (.ref_clk(ref_clk), .sys_rst(sys_rst), .chan_cmd(cmd),
    .breath_done(bd), .pulses_done(pd));
  always #5 ref_clk = ~ref_clk;
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ix, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    dat <= d;
    sel <= s;
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, ix, 32'h0, 4'hf);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    wb(1'b1, ix, d, 4'hf);
  endtask
  task automatic give_verdict;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (ack === 1'b1 && !we && exp_q.size() > 0) cmp(exp_q.pop_front(), rdat);
    if (cmd[0].restart === 1'b1) rs_seen <= 1'b1;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    void'($urandom(71));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(i), 32'h0);
    for (int i = 0; i < 5; i++) rd(8'h72 + 8'(i < 3 ? i : i + 12), 32'h0);
    r = $urandom;
    wr(LAC_IDX_POL, r);
    rd(LAC_IDX_POL, {24'h0, r[7:0]});
    wb(1'b1, LAC_IDX_POL, ~r, 4'he);
    rd(LAC_IDX_POL, {24'h0, r[7:0]});
    wr(LAC_IDX_MODE_LO, r);
    wr(LAC_IDX_MODE_HI, r >> 8);
    for (int g = 0; g < 8; g++) cmp({30'h0, cmd[g].mode}, {30'h0, r[2*g+:2]});
    rd(LAC_IDX_MODE_HI, {24'h0, r[15:8]});
    wr(LAC_IDX_MODE_LO, 32'h0);
    wr(LAC_IDX_MODE_HI, 32'h0);
    r = $urandom;
    wr(LAC_IDX_DRIVE, r);
    rd(LAC_IDX_STATUS, {24'h0, r[7:0]});
    wr(LAC_IDX_DRIVE, 32'h02);
    wr(LAC_IDX_LINK, 32'h03);
    rd(LAC_IDX_STATUS, 32'h0);
    touch <= 8'h01;
    repeat (5) @(posedge ref_clk);
    rd(LAC_IDX_STATUS, 32'h1);
    wr(LAC_IDX_LINK, 32'h00);
    wr(LAC_IDX_MODE_LO, 32'h03);
    wr(LAC_IDX_DRIVE, 32'h01);
    wr(LAC_IDX_DRIVE, 32'h00);
    rd(LAC_IDX_STATUS, 32'h1);
    repeat (40) @(posedge ref_clk);
    rd(LAC_IDX_STATUS, 32'h0);
    wr(LAC_IDX_DRIVE, 32'h01);
    pch <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pch <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmp({31'h0, rs_seen}, 32'h1);
    wr(LAC_IDX_DRIVE, 32'h00);
    wr(LAC_IDX_MODE_LO, 32'h10);
    repeat (40) @(posedge ref_clk);
    wr(LAC_IDX_DRIVE, 32'h04);
    cmp({31'h0, cmd[2].pulsing}, 32'h1);
    wr(LAC_IDX_DRIVE, 32'h00);
    wr(LAC_IDX_DRIVE, 32'h04);
    rd(LAC_IDX_STATUS, 32'h04);
    repeat (40) @(posedge ref_clk);
    rd(LAC_IDX_STATUS, 32'h0);
    wr(LAC_IDX_DRIVE, 32'h00);
    wr(LAC_IDX_MODE_LO, 32'h80);
    wr(LAC_IDX_DRIVE, 32'h08);
    cmp({31'h0, cmd[3].pulsing}, 32'h0);
    wr(LAC_IDX_DRIVE, 32'h00);
    rd(LAC_IDX_STATUS, 32'h08);
    cmp({31'h0, cmd[3].pulsing}, 32'h1);
    repeat (40) @(posedge ref_clk);
    rd(LAC_IDX_STATUS, 32'h0);
    give_verdict;
  end
endmodule // tb
bind lac_top lac_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .period_changed(period_changed), .chan_cmd(chan_cmd));
